// File: hdl/cvec_top.sv
// Converter interrupt vector generator with AXI4-Lite register slave
`timescale 1ns/1ps
`include "cvec_regs.svh"
module cvec_top
  import cvec_pkg::*;
#(
  parameter int NFLAG = 16
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             MEM_OVF_EVT,
  input  wire logic             TIME_OVF_EVT,
  input  wire logic [NFLAG-1:0] MEM_LOAD,
  input  wire logic [NFLAG-1:0] MEM_ACCESS,
  input  wire logic [11:0]      AWADDR,
  input  wire logic             AWVALID,
  output logic                  AWREADY,
  input  wire logic [31:0]      WDATA,
  input  wire logic [3:0]       WSTRB,
  input  wire logic             WVALID,
  output logic                  WREADY,
  output logic [1:0]            BRESP,
  output logic                  BVALID,
  input  wire logic             BREADY,
  input  wire logic [11:0]      ARADDR,
  input  wire logic             ARVALID,
  output logic                  ARREADY,
  output logic [31:0]           RDATA,
  output logic [1:0]            RRESP,
  output logic                  RVALID,
  input  wire logic             RREADY,
  output logic                  IRQ
);
  logic [NFLAG-1:0] flag_reg;
  logic [1:0]       status_reg;
  logic [1:0]       mask_reg;
  logic [11:0]      awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             aw_have_reg;
  logic             w_have_reg;
  cvec_word_type    vector;
  logic             wr_do;
  logic             flag_wr;
  logic             stat_wr;
  logic             mask_wr;
  logic             aw_take;
  logic             w_take;
  logic             b_take;
  logic             ar_take;
  logic             r_take;
  logic             wr_addr_ok;
  logic [1:0]       bresp_next;
  logic [NFLAG-1:0] flag_next;
  logic [1:0]       stat_clr;
  logic [1:0]       status_next;
  logic [31:0]      rdata_next;
  logic [1:0]       rresp_next;
  logic             irq_next;

  // Word index of each register; the two low address bits are ignored
  localparam logic [9:0] idx_vector = 10'(`CVEC_OFF_VECTOR >> 2);
  localparam logic [9:0] idx_flags  = 10'(`CVEC_OFF_FLAGS >> 2);
  localparam logic [9:0] idx_status = 10'(`CVEC_OFF_STATUS >> 2);
  localparam logic [9:0] idx_mask   = 10'(`CVEC_OFF_MASK >> 2);

  // Overflow sources stay pending until cleared, so they are the status bits
  cvec_prio #(
    .NFLAG (NFLAG)
  ) u_prio (
    .mem_ovf  (status_reg[`CVEC_ST_MOVF]),
    .time_ovf (status_reg[`CVEC_ST_TOVF]),
    .flags    (flag_reg),
    .vector   (vector)
  );

  assign aw_take    = AWVALID && AWREADY;
  assign w_take     = WVALID && WREADY;
  assign b_take     = BVALID && BREADY;
  assign ar_take    = ARVALID && ARREADY;
  assign r_take     = RVALID && RREADY;
  assign wr_do      = aw_have_reg && w_have_reg && !BVALID;
  assign wr_addr_ok = (awaddr_reg[11:2] == idx_flags) || (awaddr_reg[11:2] == idx_status)
                      || (awaddr_reg[11:2] == idx_mask);
  assign flag_wr    = wr_do && (awaddr_reg[11:2] == idx_flags) && (&wstrb_reg[1:0]);
  assign stat_wr    = wr_do && (awaddr_reg[11:2] == idx_status) && wstrb_reg[0];
  assign mask_wr    = wr_do && (awaddr_reg[11:2] == idx_mask) && wstrb_reg[0];
  // Vector word is read only, so a write there is refused with no effect
  assign bresp_next = wr_addr_ok ? `CVEC_RESP_OKAY : `CVEC_RESP_SLVERR;

  // Ready strobes are one-cycle pulses; a captured channel waits for the response
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
    end else begin
      AWREADY <= !aw_have_reg && !AWREADY && AWVALID;
      WREADY  <= !w_have_reg && !WREADY && WVALID;
    end
  end

  // Write address and data captured independently, in either order
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= AWADDR;
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= WDATA;
        wstrb_reg  <= WSTRB;
      end
      if (wr_do) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
      end
    end
  end

  // Write response held until the master takes it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= `CVEC_RESP_OKAY;
    end else begin
      if (wr_do) begin
        BVALID <= 1'b1;
        BRESP  <= bresp_next;
      end else if (b_take) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Result flags: load sets, access clears, software write loads the written bit; load wins, then access
  always_comb begin
    flag_next = flag_reg;
    for (int i = 0; i < NFLAG; i++) begin
      if (MEM_LOAD[i]) begin
        flag_next[i] = 1'b1;
      end else if (MEM_ACCESS[i]) begin
        flag_next[i] = 1'b0;
      end else if (flag_wr) begin
        flag_next[i] = wdata_reg[i];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flag_reg <= NFLAG'(`CVEC_RST_FLAGS);
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Overflow status, write one to clear, new event wins
  assign stat_clr    = stat_wr ? wdata_reg[1:0] : 2'h0;
  assign status_next = (status_reg & ~stat_clr) | {TIME_OVF_EVT, MEM_OVF_EVT};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_reg <= `CVEC_RST_STATUS;
      mask_reg   <= `CVEC_RST_MASK;
    end else begin
      status_reg <= status_next;
      if (mask_wr) begin
        mask_reg <= wdata_reg[1:0];
      end
    end
  end

  // No new read address while an answer still waits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b0;
    end else begin
      ARREADY <= !ARREADY && !RVALID && ARVALID;
    end
  end

  // Read decode; vector sampled live at the address handshake
  always_comb begin
    rdata_next = 32'h0000_0000;
    rresp_next = `CVEC_RESP_OKAY;
    unique case (ARADDR[11:2])
      idx_vector: rdata_next = {16'h0000, vector};
      idx_flags:  rdata_next = 32'(flag_reg);
      idx_status: rdata_next = {30'h0, status_reg};
      idx_mask:   rdata_next = {30'h0, mask_reg};
      default:    rresp_next = `CVEC_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= `CVEC_RESP_OKAY;
    end else begin
      if (ar_take) begin
        RVALID <= 1'b1;
        RDATA  <= rdata_next;
        RRESP  <= rresp_next;
      end else if (r_take) begin
        RVALID <= 1'b0;
      end
    end
  end

  // Level interrupt while any unmasked overflow status bit pends, one cycle behind status
  assign irq_next = |(status_reg & mask_reg);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_next;
    end
  end
endmodule : cvec_top

// File: hdl/cvec_regs.svh
// Register offsets, field positions and reset values of the converter interrupt vector block
`ifndef CVEC_REGS_SVH
`define CVEC_REGS_SVH
`define CVEC_OFF_VECTOR   12'h000
`define CVEC_OFF_FLAGS    12'h004
`define CVEC_OFF_STATUS   12'h008
`define CVEC_OFF_MASK     12'h00c
`define CVEC_VEC_LSB      1
`define CVEC_VEC_MSB      5
`define CVEC_CODE_NONE    5'h00
`define CVEC_CODE_MOVF    5'h01
`define CVEC_CODE_TOVF    5'h02
`define CVEC_CODE_FLAG0   5'h03
`define CVEC_RST_VECTOR   16'h0000
`define CVEC_RST_FLAGS    16'h0000
`define CVEC_RST_STATUS   2'h0
`define CVEC_RST_MASK     2'h0
`define CVEC_ST_MOVF      0
`define CVEC_ST_TOVF      1
`define CVEC_RESP_OKAY    2'h0
`define CVEC_RESP_SLVERR  2'h2
`endif

// File: hdl/cvec_pkg.sv
// Types shared by the converter interrupt vector block
package cvec_pkg;
  typedef logic [15:0] cvec_word_type;
  typedef logic [4:0]  cvec_code_type;
endpackage : cvec_pkg

// File: hdl/cvec_prio.sv
// Priority encoder turning pending sources into a vector word
`timescale 1ns/1ps
`include "cvec_regs.svh"
module cvec_prio
  import cvec_pkg::*;
#(
  parameter int NFLAG = 16
) (
  input  wire logic             mem_ovf,
  input  wire logic             time_ovf,
  input  wire logic [NFLAG-1:0] flags,
  output cvec_word_type         vector
);
  cvec_code_type code;

  always_comb begin
    code = `CVEC_CODE_NONE;
    for (int i = NFLAG - 1; i >= 0; i--) begin
      if (flags[i]) begin
        code = 5'(`CVEC_CODE_FLAG0 + i);
      end
    end
    if (time_ovf) begin
      code = `CVEC_CODE_TOVF;
    end
    if (mem_ovf) begin
      code = `CVEC_CODE_MOVF;
    end
    vector = `CVEC_RST_VECTOR;
    vector[`CVEC_VEC_MSB:`CVEC_VEC_LSB] = code;
  end
endmodule : cvec_prio

// File: verification/cvec_chk.sv
// Port-level assertions for the converter interrupt vector block
`timescale 1ns/1ps
module cvec_chk (
  input logic        CLK,
  input logic        RST,
  input logic [11:0] AWADDR,
  input logic        AWREADY,
  input logic        WREADY,
  input logic [1:0]  BRESP,
  input logic        BVALID,
  input logic [11:0] ARADDR,
  input logic        ARREADY,
  input logic [31:0] RDATA,
  input logic [1:0]  RRESP,
  input logic        RVALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  AST_VEC_ZERO: assert property (ARREADY && ARADDR == 12'h000 |=>
    RDATA[31:6] == 26'h0 && !RDATA[0]) else $error("Vector word has stray bits");
  AST_VEC_RANGE: assert property (ARREADY && ARADDR == 12'h000 |=>
    RDATA[5:1] <= 5'h12) else $error("Vector value out of range");
  AST_R_ANSWER: assert property (ARREADY |=> RVALID)
    else $error("Read answer late");
  AST_RD_ERR: assert property (ARREADY && ARADDR[11:2] > 10'h003 |=>
    RVALID && RRESP == 2'h2 && RDATA == 32'h0) else $error("Unmapped read not refused");
  AST_AR_PULSE: assert property (ARREADY |=> !ARREADY)
    else $error("Read address ready too long");
  AST_AW_PULSE: assert property (AWREADY |=> !AWREADY)
    else $error("Write address ready too long");
  AST_WR_ERR: assert property (AWREADY && AWADDR == 12'h000 |-> ##[2:8]
    BVALID && BRESP == 2'h2) else $error("Vector write not refused");
  AST_B_ANSWER: assert property (AWREADY && WREADY |-> ##2 BVALID)
    else $error("Write answer late");
  cover property (ARREADY && ARADDR == 12'h000);
  cover property (BVALID && BRESP == 2'h2);
  cover property (RVALID && RDATA[5:1] == 5'h12);
endmodule : cvec_chk

// File: verification/testbench.sv
// Self-checking bench for the converter interrupt vector block
`timescale 1ns/1ps
module testbench;
  logic CLK = 1'b0, RST = 1'b1, MEM_OVF_EVT = 1'b0, TIME_OVF_EVT = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [15:0] MEM_LOAD = 16'h0000, MEM_ACCESS = 16'h0000;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic [31:0] WDATA = 32'h0, RDATA, d;
  logic [3:0]  WSTRB = 4'hf;
  logic [1:0]  BRESP, RRESP, r;
  int          errors = 0, checked = 0, n, i;
  cvec_top dut_u (.*);
  always #10 CLK = ~CLK;
  task give_verdict();
    $display("Counts: %0d compared, %0d mismatched", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  // A stuck handshake ends the run instead of hanging it
  task hang();
    if (i >= 50) begin
      errors++;
      give_verdict();
    end
  endtask : hang
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (i = 0; i < 50 && BVALID !== 1'b1; i++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end
    r = BRESP;
    BREADY <= 1'b0;
    hang();
  endtask : wr
  task rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (i = 0; i < 50 && RVALID !== 1'b1; i++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
    hang();
    chk(e, RDATA);
    chk({30'h0, er}, {30'h0, RRESP});
  endtask : rc
  task ev(input logic [15:0] l, input logic [15:0] c, input logic [1:0] o);
    @(posedge CLK);
    MEM_LOAD <= l;
    MEM_ACCESS <= c;
    {MEM_OVF_EVT, TIME_OVF_EVT} <= o;
    @(posedge CLK);
    MEM_LOAD <= 16'h0000;
    MEM_ACCESS <= 16'h0000;
    {MEM_OVF_EVT, TIME_OVF_EVT} <= 2'h0;
  endtask : ev
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    rc(12'h000, 32'h0, 2'h0);
    for (n = 15; n >= 0; n--) begin
      ev(16'h0001 << n, 16'h0000, 2'h0);
      rc(12'h000, 32'(6 + 2 * n), 2'h0);
    end
    // Clearing lowest first walks the priority up to the last flag
    for (n = 0; n < 16; n++) begin
      ev(16'h0000, 16'h0001 << n, 2'h0);
      rc(12'h000, (n == 15) ? 32'h0 : 32'(8 + 2 * n), 2'h0);
    end
    // Load and access of one memory in one cycle leave the flag set
    ev(16'h0002, 16'h0002, 2'h0);
    rc(12'h000, 32'h8, 2'h0);
    ev(16'h0000, 16'h0002, 2'h0);
    rc(12'h000, 32'h0, 2'h0);
    $display("Test flags done");
    ev(16'h00f0, 16'h0000, 2'h1);
    rc(12'h000, 32'h4, 2'h0);
    ev(16'h0000, 16'h0000, 2'h2);
    rc(12'h000, 32'h2, 2'h0);
    chk(32'h0, {31'h0, IRQ});
    wr(12'h00c, 32'h3);
    chk(32'h0, {30'h0, r});
    repeat (2) @(posedge CLK);
    chk(32'h1, {31'h0, IRQ});
    wr(12'h008, 32'h1);
    rc(12'h000, 32'h4, 2'h0);
    wr(12'h008, 32'h2);
    rc(12'h000, 32'he, 2'h0);
    chk(32'h0, {31'h0, IRQ});
    $display("Test overflow done");
    wr(12'h004, 32'h0100);
    chk(32'h0, {30'h0, r});
    rc(12'h000, 32'h16, 2'h0);
    wr(12'h004, 32'h0);
    rc(12'h004, 32'h0, 2'h0);
    wr(12'h000, 32'h3e);
    chk(32'h2, {30'h0, r});
    rc(12'h000, 32'h0, 2'h0);
    rc(12'h010, 32'h0, 2'h2);
    $display("Test access done");
    give_verdict();
  end
endmodule : testbench
bind cvec_top cvec_chk chk_u (.*);
